// ===== verilog/apd_top.sv
// Phase and position detector top: byte register port, source mux,
// phase quality search and the position detector instance.
// Assumes video inputs and register strobes are synchronous to clk.
`timescale 1ns/1ps
`include "apd_params.svh"
// Notes on behaviour
// - Source select 00 video, 01 overlay, 10 serial receiver feeds both detectors.
// - Bypass 0 feeds converter output, 1 feeds converter input.
// - Phase detector runs only while its enable is 1.
// - Seven-bit phase total sets how many phases the search covers.
// - Six-bit phase under test; any change starts a new scan.
// - Ready bit high only while the difference sum is valid.
// - Best phase reported after all phases were scanned.
// - 24-bit difference sum for the phase under test.
// - Position detector runs only while its enable is 1.
// - Pixel active only when channel sum exceeds ten-bit threshold.
// - Left edge lock flag high when left edge locked.
// - Right edge lock flag high when right edge locked.
// - Top blank line count, vertical blanking excluded.
// - Bottom blank line count, vertical blanking excluded.
// - Left blank pixel count, horizontal blanking excluded.
// - Right blank pixel count, horizontal blanking excluded.
module apd_top
  import apd_pkg::*;
#(
  parameter int CW = 8
) (
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire logic [15:0]   reg_addr,
  input  wire logic [7:0]    reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic [7:0]         reg_rdata,
  input  wire logic [3*CW-1:0] vid_pix_in,
  input  wire logic [3*CW-1:0] vid_pix_out,
  input  wire logic          vid_de,
  input  wire logic          vid_vs,
  input  wire logic [3*CW-1:0] osd_pix_in,
  input  wire logic [3*CW-1:0] osd_pix_out,
  input  wire logic          osd_de,
  input  wire logic          osd_vs,
  input  wire logic [3*CW-1:0] rx_pix_in,
  input  wire logic [3*CW-1:0] rx_pix_out,
  input  wire logic          rx_de,
  input  wire logic          rx_vs
);
  // Reset release synchroniser
  logic rst_s1_ff, rst_n_ff;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_ff <= 1'b0;
      rst_n_ff  <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n_ff  <= rst_s1_ff;
    end
  end

  // Configuration and readback state
  logic [1:0]  detector_source_sel_ff, nxt_src;
  logic        detector_converter_bypass_ff, nxt_byp;
  logic        phase_detect_en_ff, nxt_phen;
  logic [6:0]  phase_total_count_ff, nxt_num;
  logic [5:0]  phase_under_test_ff, nxt_scan;
  logic        position_detect_en_ff, nxt_poen;
  logic [9:0]  active_pixel_threshold_ff, nxt_thr;
  logic [7:0]  rdata_ff, nxt_rdata;
  // Phase search state
  apd_ph_state_type ph_state_ff, nxt_ph_state;
  logic [23:0] acc_ff, nxt_acc, phase_diff_total_ff, nxt_sum, max_ff, nxt_max;
  logic        phase_result_valid_ff, nxt_rdy;
  logic [5:0]  best_phase_ff, nxt_best, cand_ff, nxt_cand, seen_ff, nxt_seen;
  logic [6:0]  done_ff, nxt_done;
  logic        en_seen_ff, nxt_en_seen;
  // Selected stream pipeline
  logic [3*CW-1:0] mux_pix;
  logic        mux_de, mux_vs;
  logic [9:0]  sum_ff, nxt_sumpix, prev_ff, nxt_prev;
  logic        de_ff, nxt_de, vs_ff, nxt_vs, vs_d_ff, nxt_vs_d, de_d_ff, nxt_de_d;
  // Position results
  logic [15:0] top_blank_count, bottom_blank_count;
  logic [15:0] left_blank_count, right_blank_count;
  logic        left_edge_locked, right_edge_locked;

  // Sum of the three colour channels of one pixel
  function automatic logic [9:0] chan_sum(input logic [3*CW-1:0] p);
    logic [9:0] s;
    s = 10'h000;
    for (int i = 0; i < 3; i++) begin
      s = s + 10'(p[i*CW +: CW]);
    end
    return s;
  endfunction

  // Source and feed point; unused code 11 yields a quiet stream
  always_comb begin
    mux_pix = '0;
    mux_de  = 1'b0;
    mux_vs  = 1'b0;
    case (detector_source_sel_ff)
      `APD_SRC_VID: begin
        mux_pix = detector_converter_bypass_ff ? vid_pix_in : vid_pix_out;
        mux_de  = vid_de;
        mux_vs  = vid_vs;
      end
      `APD_SRC_OSD: begin
        mux_pix = detector_converter_bypass_ff ? osd_pix_in : osd_pix_out;
        mux_de  = osd_de;
        mux_vs  = osd_vs;
      end
      `APD_SRC_RX: begin
        mux_pix = detector_converter_bypass_ff ? rx_pix_in : rx_pix_out;
        mux_de  = rx_de;
        mux_vs  = rx_vs;
      end
      default: begin
        mux_pix = '0;
        mux_de  = 1'b0;
        mux_vs  = 1'b0;
      end
    endcase
  end

  // One register stage cuts the mux from the detector arithmetic
  always_comb begin
    nxt_sumpix = chan_sum(mux_pix);
    nxt_de     = mux_de;
    nxt_vs     = mux_vs;
    nxt_vs_d   = vs_ff;
    nxt_de_d   = de_ff;
    nxt_prev   = de_ff ? sum_ff : prev_ff;
  end

  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      sum_ff  <= 10'h000;
      prev_ff <= 10'h000;
      de_ff   <= 1'b0;
      vs_ff   <= 1'b0;
      vs_d_ff <= 1'b0;
      de_d_ff <= 1'b0;
    end else begin
      sum_ff  <= nxt_sumpix;
      prev_ff <= nxt_prev;
      de_ff   <= nxt_de;
      vs_ff   <= nxt_vs;
      vs_d_ff <= nxt_vs_d;
      de_d_ff <= nxt_de_d;
    end
  end

  // Register writes and registered reads, wide fields MSB first
  always_comb begin
    nxt_src   = detector_source_sel_ff;
    nxt_byp   = detector_converter_bypass_ff;
    nxt_phen  = phase_detect_en_ff;
    nxt_num   = phase_total_count_ff;
    nxt_scan  = phase_under_test_ff;
    nxt_poen  = position_detect_en_ff;
    nxt_thr   = active_pixel_threshold_ff;
    nxt_rdata = rdata_ff;
    if (reg_wr) begin
      case (reg_addr)
        `APD_A_SRC: begin
          nxt_src = reg_wdata[1:0];
          nxt_byp = reg_wdata[`APD_BYP_BIT];
        end
        `APD_A_PHEN: begin
          nxt_phen = reg_wdata[`APD_EN_BIT];
          nxt_num  = reg_wdata[6:0];
        end
        `APD_A_SCAN: nxt_scan = reg_wdata[5:0];
        `APD_A_POEN: begin
          nxt_poen = reg_wdata[`APD_EN_BIT];
          nxt_thr  = {reg_wdata[1:0], active_pixel_threshold_ff[7:0]};
        end
        `APD_A_THR:  nxt_thr = {active_pixel_threshold_ff[9:8], reg_wdata};
        default:     nxt_thr = active_pixel_threshold_ff;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `APD_A_SRC:   nxt_rdata = {2'h0, detector_converter_bypass_ff, 3'h0,
                                   detector_source_sel_ff};
        `APD_A_PHEN:  nxt_rdata = {phase_detect_en_ff, phase_total_count_ff};
        `APD_A_SCAN:  nxt_rdata = {2'h0, phase_under_test_ff};
        `APD_A_PHST:  nxt_rdata = {phase_result_valid_ff, 1'b0, best_phase_ff};
        `APD_A_SUM2:  nxt_rdata = phase_diff_total_ff[23:16];
        `APD_A_SUM1:  nxt_rdata = phase_diff_total_ff[15:8];
        `APD_A_SUM0:  nxt_rdata = phase_diff_total_ff[7:0];
        `APD_A_POEN:  nxt_rdata = {position_detect_en_ff, 5'h00,
                                   active_pixel_threshold_ff[9:8]};
        `APD_A_THR:   nxt_rdata = active_pixel_threshold_ff[7:0];
        `APD_A_LOCK:  nxt_rdata = {left_edge_locked, right_edge_locked, 6'h00};
        `APD_A_TOP:   nxt_rdata = top_blank_count[15:8];
        `APD_A_TOP + 16'h0001:   nxt_rdata = top_blank_count[7:0];
        `APD_A_BOT:   nxt_rdata = bottom_blank_count[15:8];
        `APD_A_BOT + 16'h0001:   nxt_rdata = bottom_blank_count[7:0];
        `APD_A_LEFT:  nxt_rdata = left_blank_count[15:8];
        `APD_A_LEFT + 16'h0001:  nxt_rdata = left_blank_count[7:0];
        `APD_A_RIGHT: nxt_rdata = right_blank_count[15:8];
        `APD_A_RIGHT + 16'h0001: nxt_rdata = right_blank_count[7:0];
        default:      nxt_rdata = `APD_RST_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      detector_source_sel_ff       <= 2'(`APD_RST_SRC);
      detector_converter_bypass_ff <= 1'(`APD_RST_SRC >> `APD_BYP_BIT);
      phase_detect_en_ff           <= 1'b0;
      phase_total_count_ff         <= 7'h00;
      phase_under_test_ff          <= 6'h00;
      position_detect_en_ff        <= 1'b0;
      active_pixel_threshold_ff    <= 10'h000;
      rdata_ff                     <= `APD_RST_ZERO;
    end else begin
      detector_source_sel_ff       <= nxt_src;
      detector_converter_bypass_ff <= nxt_byp;
      phase_detect_en_ff           <= nxt_phen;
      phase_total_count_ff         <= nxt_num;
      phase_under_test_ff          <= nxt_scan;
      position_detect_en_ff        <= nxt_poen;
      active_pixel_threshold_ff    <= nxt_thr;
      rdata_ff                     <= nxt_rdata;
    end
  end
  assign reg_rdata = rdata_ff;

  // Phase search: one full frame of neighbour differences per phase.
  // A frame counts only if begun after the scan start, so a partial
  // frame never pollutes the sum.
  always_comb begin
    logic [9:0]  diff;
    logic [24:0] wide;
    logic [6:0]  total;
    diff  = 10'h000;
    wide  = 25'h0000000;
    total = (phase_total_count_ff == 7'h00) ? 7'h01 : phase_total_count_ff;
    nxt_ph_state = ph_state_ff;
    nxt_acc   = acc_ff;
    nxt_sum   = phase_diff_total_ff;
    nxt_rdy   = phase_result_valid_ff;
    nxt_best  = best_phase_ff;
    nxt_max   = max_ff;
    nxt_cand  = cand_ff;
    nxt_done  = done_ff;
    nxt_seen  = phase_under_test_ff;
    nxt_en_seen = phase_detect_en_ff;
    if (de_ff && de_d_ff) begin
      diff = (sum_ff > prev_ff) ? (sum_ff - prev_ff) : (prev_ff - sum_ff);
    end
    if (!phase_detect_en_ff) begin
      nxt_ph_state = PH_IDLE;
      nxt_rdy  = 1'b0;
      nxt_done = 7'h00;
    end else if ((phase_under_test_ff != seen_ff) || !en_seen_ff) begin
      nxt_ph_state = PH_WAIT;
      nxt_rdy = 1'b0;
      nxt_acc = 24'h000000;
    end else begin
      case (ph_state_ff)
        PH_IDLE: nxt_ph_state = PH_WAIT;
        PH_WAIT: begin
          if (vs_ff && !vs_d_ff) begin
            nxt_ph_state = PH_ACC;
            nxt_acc = 24'h000000;
          end
        end
        PH_ACC: begin
          // Saturate rather than wrap on very busy frames
          wide = {1'b0, acc_ff} + {15'h0000, diff};
          nxt_acc = wide[24] ? 24'hFFFFFF : wide[23:0];
          if (vs_ff && !vs_d_ff) begin
            nxt_ph_state = PH_DONE;
            nxt_sum = acc_ff;
            nxt_rdy = 1'b1;
            if ((done_ff == 7'h00) || (acc_ff > max_ff)) begin
              nxt_max  = acc_ff;
              nxt_cand = phase_under_test_ff;
            end
            if ((done_ff + 7'h01) >= total) begin
              nxt_best = ((done_ff == 7'h00) || (acc_ff > max_ff)) ?
                         phase_under_test_ff : cand_ff;
              nxt_done = 7'h00;
            end else begin
              nxt_done = done_ff + 7'h01;
            end
          end
        end
        PH_DONE: nxt_ph_state = PH_DONE;
        default: nxt_ph_state = PH_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      ph_state_ff           <= PH_IDLE;
      acc_ff                <= 24'h000000;
      phase_diff_total_ff   <= 24'h000000;
      phase_result_valid_ff <= 1'b0;
      best_phase_ff         <= 6'h00;
      max_ff                <= 24'h000000;
      cand_ff               <= 6'h00;
      done_ff               <= 7'h00;
      seen_ff               <= 6'h00;
      en_seen_ff            <= 1'b0;
    end else begin
      ph_state_ff           <= nxt_ph_state;
      acc_ff                <= nxt_acc;
      phase_diff_total_ff   <= nxt_sum;
      phase_result_valid_ff <= nxt_rdy;
      best_phase_ff         <= nxt_best;
      max_ff                <= nxt_max;
      cand_ff               <= nxt_cand;
      done_ff               <= nxt_done;
      seen_ff               <= nxt_seen;
      en_seen_ff            <= nxt_en_seen;
    end
  end

  // Position detector on the same selected stream
  apd_edge_scan u_edge_scan (
    .clk                (clk),
    .rst_n              (rst_n_ff),
    .en                 (position_detect_en_ff),
    .thr                (active_pixel_threshold_ff),
    .pix_sum            (sum_ff),
    .de                 (de_ff),
    .vs                 (vs_ff),
    .top_blank_count    (top_blank_count),
    .bottom_blank_count (bottom_blank_count),
    .left_blank_count   (left_blank_count),
    .right_blank_count  (right_blank_count),
    .left_edge_locked   (left_edge_locked),
    .right_edge_locked  (right_edge_locked)
  );
endmodule

// ===== verilog/apd_params.svh
// Register offsets, reset values, field positions and codes for the
// phase and position detector. Included by every detector module file.
`ifndef APD_PARAMS_SVH
`define APD_PARAMS_SVH
`define APD_A_SRC    16'h1BE0
`define APD_A_PHEN   16'h1BE1
`define APD_A_SCAN   16'h1BE2
`define APD_A_PHST   16'h1BE3
`define APD_A_SUM2   16'h1BE4
`define APD_A_SUM1   16'h1BE5
`define APD_A_SUM0   16'h1BE6
`define APD_A_POEN   16'h1BE7
`define APD_A_THR    16'h1BE8
`define APD_A_LOCK   16'h1BE9
`define APD_A_TOP    16'h1BEA
`define APD_A_BOT    16'h1BEC
`define APD_A_LEFT   16'h1BEE
`define APD_A_RIGHT  16'h1BF0
`define APD_RST_SRC  8'h20
`define APD_RST_ZERO 8'h00
`define APD_EN_BIT   7
`define APD_BYP_BIT  5
`define APD_RDY_BIT  7
`define APD_LLK_BIT  7
`define APD_RLK_BIT  6
`define APD_SRC_VID  2'h0
`define APD_SRC_OSD  2'h1
`define APD_SRC_RX   2'h2
`endif

// ===== verilog/apd_pkg.sv
// Types shared by the phase and position detector.
// Assumes apd_params.svh supplies all numeric constants.
package apd_pkg;
  typedef enum logic [1:0] {PH_IDLE, PH_WAIT, PH_ACC, PH_DONE} apd_ph_state_type;
endpackage

// ===== verilog/apd_edge_scan.sv
// Active-video position detector: blank offsets and edge lock flags.
// Assumes a registered pixel sum, data enable and vertical sync.
`timescale 1ns/1ps
`include "apd_params.svh"
module apd_edge_scan
  import apd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        en,
  input  wire logic [9:0]  thr,
  input  wire logic [9:0]  pix_sum,
  input  wire logic        de,
  input  wire logic        vs,
  output logic [15:0]      top_blank_count,
  output logic [15:0]      bottom_blank_count,
  output logic [15:0]      left_blank_count,
  output logic [15:0]      right_blank_count,
  output logic             left_edge_locked,
  output logic             right_edge_locked
);
  logic        de_d_ff, vs_d_ff, nxt_de_d, nxt_vs_d;
  logic [15:0] px_ff, ln_ff, len_ff, nxt_px, nxt_ln, nxt_len;
  logic [15:0] first_ff, last_ff, nxt_first, nxt_last;
  logic        lact_ff, fact_ff, nxt_lact, nxt_fact;
  logic [15:0] minf_ff, maxl_ff, tl_ff, bl_ff, nxt_minf, nxt_maxl, nxt_tl, nxt_bl;
  logic [15:0] top_ff, bot_ff, lft_ff, rgt_ff, nxt_top, nxt_bot, nxt_lft, nxt_rgt;
  logic        llk_ff, rlk_ff, nxt_llk, nxt_rlk;
  logic        act;

  // Pixel counts as active only above the threshold
  assign act = (pix_sum > thr);

  // Line and frame scan; results publish on each frame start that follows an active line
  always_comb begin
    nxt_de_d = de;
    nxt_vs_d = vs;
    nxt_px = px_ff;     nxt_ln = ln_ff;     nxt_len = len_ff;
    nxt_first = first_ff; nxt_last = last_ff;
    nxt_lact = lact_ff; nxt_fact = fact_ff;
    nxt_minf = minf_ff; nxt_maxl = maxl_ff; nxt_tl = tl_ff; nxt_bl = bl_ff;
    nxt_top = top_ff; nxt_bot = bot_ff; nxt_lft = lft_ff; nxt_rgt = rgt_ff;
    nxt_llk = llk_ff; nxt_rlk = rlk_ff;
    if (!en) begin
      nxt_px = 16'h0000; nxt_ln = 16'h0000; nxt_lact = 1'b0; nxt_fact = 1'b0;
      nxt_llk = 1'b0;    nxt_rlk = 1'b0;
    end else if (de_d_ff && !de) begin
      // End of line first; a frame start here waits a cycle for the fold
      nxt_vs_d = vs_d_ff;
      nxt_len = px_ff;
      nxt_ln = ln_ff + 16'h0001;
      nxt_px = 16'h0000;
      nxt_lact = 1'b0;
      if (lact_ff) begin
        nxt_bl = ln_ff;
        if (!fact_ff) begin
          nxt_tl = ln_ff;
          nxt_minf = first_ff;
          nxt_maxl = last_ff;
        end else begin
          if (first_ff < minf_ff) nxt_minf = first_ff;
          if (last_ff > maxl_ff) nxt_maxl = last_ff;
        end
        nxt_fact = 1'b1;
      end
    end else if (vs && !vs_d_ff) begin
      // Frame start; only blanking lines outside de are excluded
      if (fact_ff) begin
        nxt_top = tl_ff;
        nxt_bot = ln_ff - 16'h0001 - bl_ff;
        nxt_lft = minf_ff;
        nxt_rgt = len_ff - 16'h0001 - maxl_ff;
        nxt_llk = (minf_ff == lft_ff);
        nxt_rlk = ((len_ff - 16'h0001 - maxl_ff) == rgt_ff);
      end else begin
        nxt_llk = 1'b0;
        nxt_rlk = 1'b0;
      end
      nxt_ln = 16'h0000; nxt_fact = 1'b0; nxt_px = 16'h0000; nxt_lact = 1'b0;
    end else if (de) begin
      // Pixels outside de never enter the counts
      nxt_px = px_ff + 16'h0001;
      if (act) begin
        if (!lact_ff) nxt_first = px_ff;
        nxt_last = px_ff;
        nxt_lact = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      de_d_ff <= 1'b0;    vs_d_ff <= 1'b0;
      px_ff <= 16'h0000;  ln_ff <= 16'h0000;  len_ff <= 16'h0000;
      first_ff <= 16'h0000; last_ff <= 16'h0000;
      lact_ff <= 1'b0;    fact_ff <= 1'b0;
      minf_ff <= 16'h0000; maxl_ff <= 16'h0000; tl_ff <= 16'h0000; bl_ff <= 16'h0000;
      top_ff <= 16'h0000; bot_ff <= 16'h0000; lft_ff <= 16'h0000; rgt_ff <= 16'h0000;
      llk_ff <= 1'b0;     rlk_ff <= 1'b0;
    end else begin
      de_d_ff <= nxt_de_d; vs_d_ff <= nxt_vs_d;
      px_ff <= nxt_px;    ln_ff <= nxt_ln;    len_ff <= nxt_len;
      first_ff <= nxt_first; last_ff <= nxt_last;
      lact_ff <= nxt_lact; fact_ff <= nxt_fact;
      minf_ff <= nxt_minf; maxl_ff <= nxt_maxl; tl_ff <= nxt_tl; bl_ff <= nxt_bl;
      top_ff <= nxt_top;  bot_ff <= nxt_bot;  lft_ff <= nxt_lft;  rgt_ff <= nxt_rgt;
      llk_ff <= nxt_llk;  rlk_ff <= nxt_rlk;
    end
  end

  assign top_blank_count    = top_ff;
  assign bottom_blank_count = bot_ff;
  assign left_blank_count   = lft_ff;
  assign right_blank_count  = rgt_ff;
  assign left_edge_locked   = llk_ff;
  assign right_edge_locked  = rlk_ff;
endmodule

// ===== bench/apd_assertions.sv
// Checker for the detector register port and the phase ready timing.
// Assumes a bind to apd_top; strobes and video are synchronous to clk.
`timescale 1ns/1ps
`include "apd_params.svh"
module apd_assertions (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        vid_vs,
  input wire logic        osd_vs,
  input wire logic        rx_vs
);
  logic [7:0] src_ff, phen_ff, poen_ff, thr_ff;
  logic [5:0] scan_ff;
  logic [3:0] agep_ff, ageo_ff;
  logic       seen_ff, vs_ff, vs_sel, rd_ok;
  assign vs_sel = src_ff[1] ? rx_vs : (src_ff[0] ? osd_vs : vid_vs);
  assign rd_ok  = reg_rd && !reg_wr;
  // Shadow bytes; ages saturate so late reads stay in scope
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {src_ff, phen_ff, poen_ff, thr_ff} <= {`APD_RST_SRC, 24'h000000};
      {scan_ff, agep_ff, ageo_ff, seen_ff, vs_ff} <= '0;
    end else begin
      vs_ff <= vs_sel;
      agep_ff <= (agep_ff == 4'hF) ? agep_ff : agep_ff + 4'h1;
      ageo_ff <= (ageo_ff == 4'hF) ? ageo_ff : ageo_ff + 4'h1;
      if (vs_sel && !vs_ff) seen_ff <= 1'b1;
      // A restart wins over a frame start seen at the same edge
      if (reg_wr && reg_addr == `APD_A_SRC) src_ff <= reg_wdata;
      if (reg_wr && reg_addr == `APD_A_THR) thr_ff <= reg_wdata;
      if (reg_wr && reg_addr == `APD_A_SCAN) scan_ff <= reg_wdata[5:0];
      if (reg_wr && reg_addr == `APD_A_PHEN) phen_ff <= reg_wdata;
      if (reg_wr && reg_addr == `APD_A_POEN) poen_ff <= reg_wdata;
      if (reg_wr && reg_addr == `APD_A_POEN) ageo_ff <= '0;
      if (reg_wr && (reg_addr == `APD_A_PHEN ||
          (reg_addr == `APD_A_SCAN && reg_wdata[5:0] != scan_ff))) begin
        agep_ff <= '0;
        seen_ff <= seen_ff && reg_addr == `APD_A_PHEN && !(reg_wdata[7] && !phen_ff[7]);
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_src;
    rd_ok && reg_addr == `APD_A_SRC |=> {reg_rdata[5], reg_rdata[1:0]} ==
      {src_ff[5], src_ff[1:0]};
  endproperty
  a_src: assert property (p_src) else $error("source byte readback wrong");
  property p_phcfg;
    rd_ok && reg_addr == `APD_A_PHEN |=> reg_rdata == phen_ff;
  endproperty
  a_phcfg: assert property (p_phcfg) else $error("phase enable byte wrong");
  property p_scan;
    rd_ok && reg_addr == `APD_A_SCAN |=> reg_rdata[5:0] == scan_ff;
  endproperty
  a_scan: assert property (p_scan) else $error("phase under test wrong");
  property p_thr;
    rd_ok && reg_addr == `APD_A_THR |=> reg_rdata == thr_ff;
  endproperty
  a_thr: assert property (p_thr) else $error("threshold low byte wrong");
  property p_poen;
    rd_ok && reg_addr == `APD_A_POEN |=> {reg_rdata[7], reg_rdata[1:0]} ==
      {poen_ff[7], poen_ff[1:0]};
  endproperty
  a_poen: assert property (p_poen) else $error("position byte wrong");
  property p_unmap;
    reg_rd && (reg_addr < `APD_A_SRC || reg_addr > 16'h1BF1) |=> reg_rdata == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_hold;
    !reg_rd |=> $stable(reg_rdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved without read");
  property p_phoff;
    rd_ok && reg_addr == `APD_A_PHST && !phen_ff[7] && agep_ff > 4'h3 |=> !reg_rdata[7];
  endproperty
  a_phoff: assert property (p_phoff) else $error("ready while disabled");
  property p_wait;
    rd_ok && reg_addr == `APD_A_PHST && agep_ff > 4'h3 && !seen_ff |=> !reg_rdata[7];
  endproperty
  a_wait: assert property (p_wait) else $error("ready before any frame");
  property p_pooff;
    rd_ok && reg_addr == `APD_A_LOCK && !poen_ff[7] && ageo_ff > 4'h7 |=>
      reg_rdata[7:6] == 2'b00;
  endproperty
  a_pooff: assert property (p_pooff) else $error("lock while disabled");
endmodule

// ===== bench/apd_video_model.sv
// Behavioural video source: free-running frames with one lit rectangle.
// Assumes clk is the pixel clock; blank channels sit at 16.
`timescale 1ns/1ps
module apd_video_model #(
  parameter logic [15:0] GEOM  = 16'h1111, // Top, bottom, left, right blank nibbles
  parameter int          LINES = 8,
  parameter int          LLEN  = 16
) (
  input  wire logic        clk,
  input  wire logic [7:0]  level,
  output logic      [23:0] pix_in,
  output logic      [23:0] pix_out,
  output logic             de,
  output logic             vs
);
  localparam int T = int'(GEOM[15:12]), B = int'(GEOM[11:8]);
  localparam int L = int'(GEOM[7:4]), R = int'(GEOM[3:0]);
  logic [7:0] junk = 8'h5A;
  logic       row;
  // Lit pixels carry level on all channels
  function automatic logic [23:0] pel(input logic lit);
    return lit ? {3{level}} : {3{8'h10}};
  endfunction
  // Four blank lines then visible lines; junk outside de so blanking is ignored
  initial begin
    {pix_in, pix_out, de, vs} = '0;
    forever begin
      for (int ln = -4; ln < LINES; ln++) begin
        for (int px = -4; px < LLEN; px++) begin
          @(posedge clk);
          #1;
          row = ln >= T && ln < LINES - B;
          junk = junk + 8'h3B;
          vs = (ln == -4);
          de = (ln >= 0) && (px >= 0);
          pix_in = de ? pel(row && px >= L && px < LLEN - R) : {3{junk}};
          pix_out = de ? pel(row && px > L && px < LLEN - R) : {3{~junk}};
        end
      end
    end
  end
endmodule

// ===== bench/tb_auto_phase_position_detect.sv
// Self-checking bench for the phase and position detector.
// Assumes three apd_video_model sources of 8 lines by 16 pixels.
`timescale 1ns/1ps
`include "apd_params.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_auto_phase_position_detect;
  logic        clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0;
  logic [15:0] reg_addr = '0, d16, a;
  logic [7:0]  reg_wdata = '0, reg_rdata, d, lvl = 8'h80;
  logic [23:0] v_pi, v_po, o_pi, o_po, r_pi, r_po, sum;
  logic        v_de, v_vs, o_de, o_vs, r_de, r_vs;
  logic [1:0]  src = 2'h0;
  int          error_cnt = 0, checks_done = 0, cyc = 0, j;
  wire         vs_sel = src[1] ? r_vs : (src[0] ? o_vs : v_vs);
  // Rows: source, bypass, then top, bottom, left, right expected
  logic [66:0] rows [6] = '{{2'h0, 1'h1, 16'h1, 16'h2, 16'h3, 16'h2},
    {2'h0, 1'h0, 16'h1, 16'h2, 16'h4, 16'h2}, {2'h1, 1'h1, 16'h2, 16'h1, 16'h2, 16'h4},
    {2'h1, 1'h0, 16'h2, 16'h1, 16'h3, 16'h4}, {2'h2, 1'h1, 16'h0, 16'h3, 16'h1, 16'h1},
    {2'h2, 1'h0, 16'h0, 16'h3, 16'h2, 16'h1}};
  logic [7:0]  lv [3] = '{8'h40, 8'h90, 8'h60};
  always #12.5 clk = ~clk;
  apd_top u_dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .vid_pix_in(v_pi), .vid_pix_out(v_po), .vid_de(v_de), .vid_vs(v_vs),
    .osd_pix_in(o_pi), .osd_pix_out(o_po), .osd_de(o_de), .osd_vs(o_vs),
    .rx_pix_in(r_pi), .rx_pix_out(r_po), .rx_de(r_de), .rx_vs(r_vs));
  apd_video_model #(.GEOM(16'h1232)) u_vid (.clk(clk), .level(lvl),
    .pix_in(v_pi), .pix_out(v_po), .de(v_de), .vs(v_vs));
  apd_video_model #(.GEOM(16'h2124)) u_osd (.clk(clk), .level(lvl),
    .pix_in(o_pi), .pix_out(o_po), .de(o_de), .vs(o_vs));
  apd_video_model #(.GEOM(16'h0311)) u_rx (.clk(clk), .level(lvl),
    .pix_in(r_pi), .pix_out(r_po), .de(r_de), .vs(r_vs));
  task automatic pause(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask
  // Each access leaves a free edge so strobes never toggle twice at once
  task automatic wr(input logic [15:0] ad, input logic [7:0] v);
    reg_addr = ad;
    reg_wdata = v;
    reg_wr = 1'b1;
    pause(1);
    reg_wr = 1'b0;
    pause(1);
  endtask
  task automatic rd(input logic [15:0] ad);
    reg_addr = ad;
    reg_rd = 1'b1;
    pause(1);
    reg_rd = 1'b0;
    d = reg_rdata;
    pause(1);
  endtask
  task automatic rd16(input logic [15:0] ad);
    rd(ad);
    d16[15:8] = d;
    rd(ad + 16'h1);
    d16[7:0] = d;
  endtask
  task automatic frames(input int n);
    repeat (n) @(posedge vs_sel);
    pause(4);
  endtask
  task automatic wrap_up();
    if (error_cnt == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Hang guard, about four times the expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      wrap_up();
    end
  end
  initial begin
    pause(6);
    rstn = 1'b1;
    pause(3);
    wr(`APD_A_THR, 8'h7F);
    wr(`APD_A_POEN, 8'h81);
    // Lit sum 384 sits one above the threshold
    foreach (rows[k]) begin
      src = rows[k][66:65];
      wr(`APD_A_SRC, {2'b00, rows[k][64], 3'b000, src});
      frames(4);
      rd16(`APD_A_TOP); `CHK(d16, rows[k][63:48])
      rd16(`APD_A_BOT); `CHK(d16, rows[k][47:32])
      rd16(`APD_A_LEFT); `CHK(d16, rows[k][31:16])
      rd16(`APD_A_RIGHT); `CHK(d16, rows[k][15:0])
      rd(`APD_A_LOCK); `CHK(d[7:6], 2'b11)
    end
    wr(`APD_A_POEN, 8'h01);
    pause(10);
    rd(`APD_A_LOCK); `CHK(d[7:6], 2'b00)
    // Three phases; the middle one has the strongest edges
    src = 2'h0;
    wr(`APD_A_SRC, 8'h20);
    for (int i = 0; i < 3; i++) begin
      lvl = lv[i];
      if (i == 0) wr(`APD_A_PHEN, 8'h83);
      else wr(`APD_A_SCAN, 8'(i));
      pause(5);
      rd(`APD_A_PHST); `CHK(d[7], 1'b0)
      for (j = 0; j < 600 && d[7] !== 1'b1; j++) rd(`APD_A_PHST);
      `CHK(d[7], 1'b1)
      rd(`APD_A_SUM2);
      sum[23:16] = d;
      rd(`APD_A_SUM1);
      sum[15:8] = d;
      rd(`APD_A_SUM0);
      sum[7:0] = d;
      `CHK(sum, 24'(10 * (3 * lv[i] - 48)))
    end
    rd(`APD_A_PHST); `CHK(d[5:0], 6'h01)
    wr(`APD_A_PHEN, 8'h03);
    pause(5);
    rd(`APD_A_PHST); `CHK(d[7], 1'b0)
    // Threshold equal to the lit sum leaves nothing active
    lvl = 8'h80;
    wr(`APD_A_POEN, 8'h81);
    wr(`APD_A_THR, 8'h80);
    frames(3);
    rd(`APD_A_LOCK); `CHK(d[7:6], 2'b00)
    wr(`APD_A_THR, 8'h7F);
    src = 2'h3;
    wr(`APD_A_SRC, 8'h23);
    frames(3);
    rd(`APD_A_LOCK); `CHK(d[7:6], 2'b00)
    // Second reset mid-run, then the whole map and refused accesses
    rstn = 1'b0;
    pause(6);
    rstn = 1'b1;
    pause(3);
    for (a = `APD_A_SRC; a <= 16'h1BF1; a++) begin
      rd(a); `CHK(d, (a == `APD_A_SRC) ? `APD_RST_SRC : `APD_RST_ZERO)
    end
    wr(`APD_A_PHST, 8'hFF);
    wr(`APD_A_SUM0, 8'hFF);
    rd(`APD_A_SUM0); `CHK(d, 8'h00)
    rd(`APD_A_PHST); `CHK(d, 8'h00)
    rd(16'h1BDF); `CHK(d, 8'h00)
    rd(16'h1BF2); `CHK(d, 8'h00)
    wrap_up();
  end
endmodule
bind apd_top apd_assertions u_chk (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .vid_vs(vid_vs), .osd_vs(osd_vs), .rx_vs(rx_vs));
